//--- testbench/cic_ctrl_assertions.sv
`timescale 1ns/10ps
module cic_ctrl_checker (
  // Clock, reset and bus
  input wire logic                 mclk,
  input wire logic                 rst_b,
  input wire logic                 psel,
  input wire logic                 penable,
  input wire logic                 pwrite,
  input wire logic [7:0]           paddr,
  input wire logic [31:0]          pwdata,
  // Pins, units and summary
  input wire logic                 reset_powerdown_pin_n,
  input wire cic_pkg::cic_events_t events,
  input wire cic_pkg::cic_ctrl_t   ctrl,
  input wire logic                 high_priority_summary
);
  import cic_pkg::*;
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_b);

  a_hard_stop: assert property (!reset_powerdown_pin_n [*3] |=> !ctrl.unit_run && !ctrl.detector_run)
    else $error("units run in hard power-down");
  a_abort_run: assert property (ctrl.cmd_abort |-> $past(ctrl.cmd_code) != CIC_CMD_IDLE)
    else $error("abort without a running command");
  a_arg_count: assert property (ctrl.cmd_launch && ctrl.cmd_code == CIC_CMD_AUTHENT |->
    $past(events.fifo_level) >= CIC_AUTH_ARGS) else $error("launch before all arguments");
  a_tx_source: assert property (ctrl.tx_launch |->
    ctrl.cmd_code == CIC_CMD_TRANSMIT || ctrl.cmd_code == CIC_CMD_TRANSCEIVE) else $error("stray transmit");
  a_tx_with: assert property (ctrl.cmd_launch && ctrl.cmd_code == CIC_CMD_TRANSMIT |-> ctrl.tx_launch)
    else $error("transmit command without transmit");
  a_done_idle: assert property (events.cmd_done && ctrl.unit_run && !psel |=> ctrl.cmd_code == CIC_CMD_IDLE)
    else $error("finished command not idle");
  a_sum_hold: assert property (high_priority_summary && !(psel && penable && pwrite) |=>
    high_priority_summary) else $error("summary dropped without a write");
  a_keep_code: assert property (psel && penable && pwrite && paddr == CIC_COMMAND_OFS &&
    pwdata[3:0] == CIC_CMD_KEEP && !events.cmd_done |=> ctrl.cmd_code == $past(ctrl.cmd_code) && !ctrl.cmd_abort)
    else $error("keep code changed the command");
  a_soft_pd: assert property (ctrl.force_conductance |-> !ctrl.unit_run && ctrl.detector_run)
    else $error("forced drivers outside soft power-down");
endmodule

bind cic_ctrl cic_ctrl_checker chk_u (
  .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
  .pwdata(pwdata), .reset_powerdown_pin_n(reset_powerdown_pin_n), .events(events), .ctrl(ctrl),
  .high_priority_summary(high_priority_summary)
);

//--- testbench/cic_ctrl_tb.sv
`timescale 1ns/10ps
module cic_ctrl_tb;
  import cic_pkg::*;
  logic             mclk = 1'h0;
  logic             rst_b = 1'h0;
  logic             psel = 1'h0;
  logic             penable = 1'h0;
  logic             pwrite = 1'h0;
  logic [7:0]       paddr = 8'h00;
  logic [31:0]      pwdata = 32'h0;
  logic             reset_powerdown_pin_n = 1'h1;
  logic             field_detect = 1'h0;
  logic             pready;
  logic             pslverr;
  logic             hi_sum;
  logic             lo_sum;
  logic [31:0]      prdata;
  logic [31:0]      rd;
  cic_ctrl_t        ctrl;
  wire cic_events_t events;
  int               failures = 0;
  int               compares = 0;
  int               launches = 0;
  int               tx_starts = 0;
  int               aborts = 0;
  int               base;

  always #25 mclk = ~mclk;

  cic_ctrl dut_u (
    .mclk(mclk), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .reset_powerdown_pin_n(reset_powerdown_pin_n), .field_detect(field_detect), .events(events),
    .ctrl(ctrl), .high_priority_summary(hi_sum), .low_priority_summary(lo_sum)
  );
  cic_unit_model unit_u (.mclk(mclk), .ctrl(ctrl), .events(events));

  always @(posedge mclk) begin
    launches += int'(ctrl.cmd_launch === 1'h1);
    tx_starts += int'(ctrl.tx_launch === 1'h1);
    aborts += int'(ctrl.cmd_abort === 1'h1);
  end

  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    // Only the watchdog ends a wait
    do begin
      @(posedge mclk);
    end while (pready !== 1'h1);
    // No register is 32 bits wide, so bit 31 carries the error response
    rd = prdata | {pslverr, 31'h0};
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'h1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    apb(1'h0, a, 32'h0);
    check(nm, rd, exp);
  endtask

  task automatic sums(input string nm, input logic [1:0] exp);
    check(nm, {30'h0, hi_sum, lo_sum}, {30'h0, exp});
  endtask

  // Unit run, detector, receiver, driver a, driver b, forced conductance
  function automatic logic [31:0] units();
    return {26'h0, ctrl.unit_run, ctrl.detector_run, ctrl.receiver_on,
            ctrl.antenna_a_on, ctrl.antenna_b_on, ctrl.force_conductance};
  endfunction

  // Exactly one flag set and summarised, then cleared and quiet again
  task automatic flag(input logic [7:0] a, input int b, input logic [1:0] s);
    cyc(4);
    sums("summary set", s);
    rdc("flag set", a, 32'h1 << b);
    wr(a, 32'h1 << b);
    cyc(1);
    sums("summary clear", 2'h0);
  endtask

  task automatic t_regs();
    rdc("status", CIC_STATUS_ONE_OFS, 32'h4);
    rdc("command", CIC_COMMAND_OFS, 32'h0);
    wr(CIC_COMM_FLAGS_OFS, 32'h7F);
    rdc("unmapped", 8'h3C, 32'h8000_0000);
  endtask

  task automatic t_high();
    wr(CIC_COMM_EN_OFS, {25'h0, CIC_HIGH_GROUP});
    wr(CIC_WATERMARK_OFS, 32'h8);
    unit_u.events.fifo_level <= 7'h14;
    cyc(3);
    unit_u.events.fifo_level <= 7'h08;
    flag(CIC_COMM_FLAGS_OFS, CIC_LOW_BIT, 2'h2);
    unit_u.events.fifo_level <= 7'h38;
    flag(CIC_COMM_FLAGS_OFS, CIC_HIGH_BIT, 2'h2);
    unit_u.events.rx_stream_end <= 1'h1;
    cyc(1);
    unit_u.events.rx_stream_end <= 1'h0;
    flag(CIC_COMM_FLAGS_OFS, CIC_RX_BIT, 2'h2);
  endtask

  task automatic t_low();
    wr(CIC_COMM_EN_OFS, {25'h0, CIC_LOW_GROUP});
    wr(CIC_MISC_EN_OFS, 32'hF);
    unit_u.events.timer_count <= 16'h0002;
    cyc(2);
    unit_u.events.timer_count <= 16'h0001;
    cyc(2);
    unit_u.events.timer_count <= 16'h0000;
    flag(CIC_COMM_FLAGS_OFS, CIC_TIMER_BIT, 2'h1);
    unit_u.events.error_status <= 8'h10;
    unit_u.events.rx_active <= 1'h1;
    cyc(2);
    unit_u.events.error_status <= 8'h00;
    flag(CIC_COMM_FLAGS_OFS, CIC_ERR_BIT, 2'h1);
    unit_u.events.mode_found <= 1'h1;
    cyc(1);
    unit_u.events.mode_found <= 1'h0;
    flag(CIC_MISC_FLAGS_OFS, CIC_MODE_BIT, 2'h1);
    unit_u.events.checksum_ready_status <= 1'h1;
    flag(CIC_MISC_FLAGS_OFS, CIC_CRC_BIT, 2'h1);
    field_detect <= 1'h1;
    flag(CIC_MISC_FLAGS_OFS, CIC_ON_BIT, 2'h1);
    field_detect <= 1'h0;
    flag(CIC_MISC_FLAGS_OFS, CIC_OFF_BIT, 2'h1);
    wr(CIC_MISC_EN_OFS, 32'h0);
  endtask

  task automatic t_cmds();
    wr(CIC_COMM_EN_OFS, (32'h1 << CIC_TX_BIT) | (32'h1 << CIC_IDLE_BIT));
    base = tx_starts;
    wr(CIC_COMMAND_OFS, {28'h0, CIC_CMD_TRANSMIT});
    cyc(14);
    check("tx start", 32'(tx_starts - base), 32'h1);
    rdc("tx idle", CIC_COMMAND_OFS, 32'h0);
    rdc("tx flags", CIC_COMM_FLAGS_OFS, (32'h1 << CIC_TX_BIT) | (32'h1 << CIC_IDLE_BIT));
    sums("tx sums", 2'h3);
    wr(CIC_COMM_FLAGS_OFS, 32'h7F);
    base = tx_starts;
    wr(CIC_COMMAND_OFS, {28'h0, CIC_CMD_TRANSCEIVE});
    cyc(6);
    check("trx held", 32'(tx_starts - base), 32'h0);
    wr(CIC_BIT_FRAMING_OFS, 32'h1 << CIC_BEGIN_BIT);
    cyc(14);
    check("trx sent", 32'(tx_starts - base), 32'h1);
    rdc("trx idle", CIC_COMMAND_OFS, 32'h0);
  endtask

  task automatic t_args();
    unit_u.events.fifo_level <= CIC_AUTH_ARGS - 7'h1;
    base = launches;
    wr(CIC_COMMAND_OFS, {28'h0, CIC_CMD_AUTHENT});
    cyc(6);
    check("early launch", 32'(launches - base), 32'h0);
    unit_u.events.fifo_level <= CIC_AUTH_ARGS;
    cyc(5);
    check("launch", 32'(launches - base), 32'h1);
    unit_u.events.fifo_level <= 7'h00;
    base = aborts;
    wr(CIC_COMMAND_OFS, {28'h0, CIC_CMD_IDLE});
    cyc(3);
    check("abort", 32'(aborts - base), 32'h1);
    rdc("cancelled", CIC_COMMAND_OFS, 32'h0);
    wr(CIC_COMM_FLAGS_OFS, 32'h7F);
  endtask

  task automatic t_soft();
    wr(CIC_TX_DRIVER_OFS, 32'h10);
    wr(CIC_COMMAND_OFS, 32'h8);
    wr(CIC_COMMAND_OFS, {27'h1, CIC_CMD_KEEP});
    cyc(2);
    check("soft units", units(), 32'h11);
    rdc("keep code", CIC_COMMAND_OFS, 32'h18);
    rdc("retained", CIC_WATERMARK_OFS, 32'h8);
    wr(CIC_COMMAND_OFS, {28'h0, CIC_CMD_KEEP});
    cyc(CIC_EXIT_CLOCKS - 30);
    rdc("still down", CIC_COMMAND_OFS, 32'h18);
    cyc(40);
    rdc("exited", CIC_COMMAND_OFS, 32'h8);
    check("units back", units(), 32'h38);
    wr(CIC_COMMAND_OFS, 32'h0);
    wr(CIC_TX_DRIVER_OFS, 32'h0);
    wr(CIC_TX_AUTO_OFS, 32'h1 << CIC_WAKE_BIT);
    wr(CIC_COMMAND_OFS, 32'h1 << CIC_PD_BIT);
    cyc(2);
    check("asleep", units(), 32'h10);
    field_detect <= 1'h1;
    cyc(CIC_EXIT_CLOCKS + 20);
    rdc("woken", CIC_COMMAND_OFS, 32'h0);
    check("awake", units(), 32'h38);
    field_detect <= 1'h0;
    wr(CIC_TX_AUTO_OFS, 32'h0);
    wr(CIC_MISC_FLAGS_OFS, 32'hF);
  endtask

  task automatic t_pins();
    wr(CIC_TX_AUTO_OFS, 32'h1 << CIC_INIT_BIT);
    wr(CIC_TX_DRIVER_OFS, 32'h3);
    cyc(1);
    check("drivers on", units(), 32'h3E);
    wr(CIC_TX_AUTO_OFS, 32'h0);
    wr(CIC_TX_DRIVER_OFS, 32'h0);
    cyc(1);
    check("drivers off", units(), 32'h38);
    base = launches;
    reset_powerdown_pin_n <= 1'h0;
    cyc(4);
    check("hard down", units(), 32'h0);
    wr(CIC_COMMAND_OFS, {28'h0, CIC_CMD_TRANSMIT});
    reset_powerdown_pin_n <= 1'h1;
    cyc(6);
    check("no launch", 32'(launches - base), 32'h0);
    check("units up", units(), 32'h38);
  endtask

  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  initial begin
    cyc(12);
    rst_b <= 1'h1;
    cyc(4);
    t_regs();
    t_high();
    t_low();
    t_cmds();
    t_args();
    t_soft();
    t_pins();
    final_report();
  end

  // Whole run is about 2400 cycles
  initial begin
    cyc(10000);
    failures++;
    final_report();
  end
endmodule

//--- testbench/cic_unit_model.sv
`timescale 1ns/10ps
module cic_unit_model (
  // Clock and control from the block
  input  wire logic               mclk,
  input  wire cic_pkg::cic_ctrl_t ctrl,
  // Unit events back to the block
  output cic_pkg::cic_events_t    events
);
  import cic_pkg::*;
  logic [2:0] phase;

  // Fields not sequenced here are set by the bench as stimulus
  initial begin
    events = '0;
    phase = 3'h0;
  end

  // Four payload cycles, one end-of-frame cycle, then the sequencer ends
  always @(posedge mclk) begin
    if (ctrl.tx_launch && ctrl.unit_run) begin
      phase <= 3'h1;
    end else if (phase != 3'h0) begin
      phase <= phase + 3'h1;
    end
    events.tx_payload <= (phase != 3'h0) && (phase < 3'h5);
    events.tx_eof <= phase == 3'h5;
    events.cmd_done <= phase == 3'h6;
  end
endmodule

//--- verilog/cic_ctrl.sv
// Function
// RQ1 - Timer flag set when timer count goes from one to zero.
// RQ2 - Transmit-done flag set when payload phase turns into end-of-frame.
// RQ3 - Checksum-done flag set when checksum ready status rises.
// RQ4 - Receive-done flag set at end of received stream.
// RQ5 - Command-finished flag set when running command completes back to idle.
// RQ6 - Almost-full and almost-empty flags set on watermark status rising.
// RQ7 - Field appeared and vanished flags follow the level detector.
// RQ8 - Error flag set while any error bit is one during transfer.
// RQ9 - Mode-detected flag set when the mode detector reports.
// RQ10 - Transmit, receive and watermark flags form the high summary.
// RQ11 - Remaining flags form the low summary.
// RQ12 - Reset/power-down pin low stops all units, detector too.
// RQ13 - Soft power-down stops units except oscillator and detector, keeps state.
// RQ14 - With wake enable, a detected field ends soft power-down.
// RQ15 - Power-down bit reads one for 1024 cycles after cleared.
// RQ16 - Soft power-down with nonzero driver select forces driver conductance.
// RQ17 - Both driver enables clear turns field off, receiver stays on.
// RQ18 - Firmware clears initial field option before dropping driver enables.
// RQ19 - Command starts when its code is written to the command register.
// RQ20 - Transceive transmits only after the begin-transmission bit is set.
// RQ21 - Argument commands wait for full argument count; FIFO not flushed.
// RQ22 - Writing a new command code aborts the running command.
// RQ23 - Code 0000 is idle and cancels the running command.
// RQ24 - Code 0111 keeps the command while other bits change.
// RQ25 - Each summary stays high while any enabled flag in group is set.
//
// The APB slave port and the address map are this design's own decisions.
`timescale 1ns/10ps
module cic_ctrl (
  // Clock and reset
  input  wire logic                 mclk,
  input  wire logic                 rst_b,
  // APB slave
  input  wire logic                 psel,
  input  wire logic                 penable,
  input  wire logic                 pwrite,
  input  wire logic [7:0]           paddr,
  input  wire logic [31:0]          pwdata,
  output logic                      pready,
  output logic [31:0]               prdata,
  output logic                      pslverr,
  // Pins
  input  wire logic                 reset_powerdown_pin_n,
  input  wire logic                 field_detect,
  // Unit events
  input  wire cic_pkg::cic_events_t events,
  // Unit control
  output cic_pkg::cic_ctrl_t        ctrl,
  output logic                      high_priority_summary,
  output logic                      low_priority_summary
);
  import cic_pkg::*;

  cic_state_t state;
  cic_state_t next_state;

  function automatic logic [6:0] args_needed(input logic [3:0] code);
    args_needed = (code == CIC_CMD_AUTHENT) ? CIC_AUTH_ARGS : 7'h00;
  endfunction

  function automatic logic [31:0] read_reg(input cic_state_t s, input logic [7:0] addr,
                                           input logic [7:0] err, input logic crc_rdy);
    unique case (addr)
      CIC_COMM_FLAGS_OFS:  read_reg = {25'h0, s.comm_flags};
      CIC_MISC_FLAGS_OFS:  read_reg = {28'h0, s.misc_flags};
      CIC_COMM_EN_OFS:     read_reg = {25'h0, s.comm_en};
      CIC_MISC_EN_OFS:     read_reg = {28'h0, s.misc_en};
      CIC_STATUS_ONE_OFS:  read_reg = {26'h0, s.field_prev, crc_rdy, s.high_prev,
                                       s.low_prev, s.low_irq, s.high_irq};
      CIC_ERROR_OFS:       read_reg = {24'h0, err};
      CIC_WATERMARK_OFS:   read_reg = {26'h0, s.watermark};
      CIC_COMMAND_OFS:     read_reg = {27'h0, s.pd_active, s.ctrl.cmd_code};
      CIC_TX_DRIVER_OFS:   read_reg = {26'h0, s.drv_sel, 2'h0, s.drv_en};
      CIC_TX_AUTO_OFS:     read_reg = {28'h0, s.auto_ctrl};
      CIC_BIT_FRAMING_OFS: read_reg = {24'h0, s.begin_tx, 7'h00};
      default:             read_reg = 32'h0;
    endcase
  endfunction

  function automatic logic mapped(input logic [7:0] addr);
    mapped = (addr <= CIC_BIT_FRAMING_OFS) && (addr[1:0] == 2'h0);
  endfunction

  logic       wr;
  logic       pin_up;
  logic       field;
  logic       high_mark;
  logic       low_mark;
  logic [6:0] comm_set;
  logic [3:0] misc_set;
  logic [3:0] new_code;
  logic       new_cmd;
  logic       pd_write;

  always_comb begin
    next_state = state;
    wr = psel && penable && state.ready && pwrite;
    pin_up = state.pin_sync[1];
    field = state.field_sync[1];
    new_code = pwdata[3:0];
    new_cmd = 1'b0;
    pd_write = 1'b0;
    comm_set = 7'h00;
    misc_set = 4'h0;

    // Pins pass two flops before use
    next_state.pin_sync = {state.pin_sync[0], reset_powerdown_pin_n};
    next_state.field_sync = {state.field_sync[0], field_detect};
    // Detector is dead in hard power-down
    next_state.field_prev = pin_up ? field : 1'b0; // [RQ12]

    high_mark = (CIC_FIFO_DEPTH - events.fifo_level) <= {1'b0, state.watermark}; // [RQ6]
    low_mark = events.fifo_level <= {1'b0, state.watermark}; // [RQ6]
    next_state.timer_prev = events.timer_count;
    next_state.payload_prev = events.tx_payload;
    next_state.crc_prev = events.checksum_ready_status;
    next_state.high_prev = high_mark;
    next_state.low_prev = low_mark;

    // Pulses last one cycle
    next_state.ctrl.cmd_launch = 1'b0;
    next_state.ctrl.cmd_abort = 1'b0;
    next_state.ctrl.tx_launch = 1'b0;

    // Event detection, ignored while the pin holds units down
    if (pin_up) begin
      comm_set[CIC_TIMER_BIT] = (state.timer_prev == 16'h0001) && (events.timer_count == 16'h0000); // [RQ1]
      comm_set[CIC_TX_BIT] = state.payload_prev && events.tx_eof; // [RQ2]
      misc_set[CIC_CRC_BIT] = events.checksum_ready_status && !state.crc_prev; // [RQ3]
      comm_set[CIC_RX_BIT] = events.rx_stream_end; // [RQ4]
      comm_set[CIC_HIGH_BIT] = high_mark && !state.high_prev; // [RQ6]
      comm_set[CIC_LOW_BIT] = low_mark && !state.low_prev; // [RQ6]
      misc_set[CIC_ON_BIT] = field && !state.field_prev; // [RQ7]
      misc_set[CIC_OFF_BIT] = !field && state.field_prev; // [RQ7]
      comm_set[CIC_ERR_BIT] = (|events.error_status) && (events.tx_active || events.rx_active); // [RQ8]
      misc_set[CIC_MODE_BIT] = events.mode_found; // [RQ9]
      if (events.cmd_done && (state.ctrl.cmd_code != CIC_CMD_IDLE)) begin
        comm_set[CIC_IDLE_BIT] = 1'b1; // [RQ5]
        next_state.ctrl.cmd_code = CIC_CMD_IDLE; // [RQ5]
        next_state.cmd_pending = 1'b0;
        next_state.begin_tx = 1'b0;
      end
    end

    // APB setup phase: answer next cycle
    next_state.ready = psel && !penable;
    next_state.slverr = psel && !penable && !mapped(paddr);
    next_state.rdata = (psel && !penable && !pwrite) ?
                       read_reg(state, paddr, events.error_status, events.checksum_ready_status) : 32'h0;

    // Flags: write one clears, a set in the same cycle wins
    next_state.comm_flags = state.comm_flags;
    next_state.misc_flags = state.misc_flags;
    if (wr && (paddr == CIC_COMM_FLAGS_OFS)) begin
      next_state.comm_flags = state.comm_flags & ~pwdata[6:0];
    end
    if (wr && (paddr == CIC_MISC_FLAGS_OFS)) begin
      next_state.misc_flags = state.misc_flags & ~pwdata[3:0];
    end
    next_state.comm_flags = next_state.comm_flags | comm_set;
    next_state.misc_flags = next_state.misc_flags | misc_set;

    if (wr) begin
      unique case (paddr)
        CIC_COMM_EN_OFS:     next_state.comm_en = pwdata[6:0];
        CIC_MISC_EN_OFS:     next_state.misc_en = pwdata[3:0];
        CIC_WATERMARK_OFS:   next_state.watermark = pwdata[5:0];
        CIC_TX_DRIVER_OFS: begin
          next_state.drv_en = pwdata[1:0];
          next_state.drv_sel = pwdata[5:4];
        end
        CIC_TX_AUTO_OFS:     next_state.auto_ctrl = pwdata[3:0];
        CIC_BIT_FRAMING_OFS: begin
          if (pwdata[CIC_BEGIN_BIT] && (state.ctrl.cmd_code == CIC_CMD_TRANSCEIVE)) begin
            next_state.begin_tx = 1'b1;
            next_state.ctrl.tx_launch = 1'b1; // [RQ20]
          end
        end
        CIC_COMMAND_OFS: begin
          pd_write = 1'b1;
          new_cmd = new_code != CIC_CMD_KEEP; // [RQ24]
        end
        default: begin
        end
      endcase
    end

    // Command launch; the FIFO is left as it is
    if (new_cmd && pin_up) begin
      next_state.ctrl.cmd_abort = state.ctrl.cmd_code != CIC_CMD_IDLE; // [RQ22] [RQ23]
      next_state.ctrl.cmd_code = new_code; // [RQ19]
      next_state.begin_tx = 1'b0;
      next_state.cmd_pending = new_code != CIC_CMD_IDLE; // [RQ23]
    end
    if (state.cmd_pending && !new_cmd && (events.fifo_level >= args_needed(state.ctrl.cmd_code))) begin
      next_state.cmd_pending = 1'b0; // [RQ21]
      next_state.ctrl.cmd_launch = 1'b1; // [RQ19]
      next_state.ctrl.tx_launch = state.ctrl.cmd_code == CIC_CMD_TRANSMIT; // [RQ20]
    end

    // Soft power-down entry and delayed exit
    if (pd_write && pwdata[CIC_PD_BIT]) begin
      next_state.pd_active = 1'b1; // [RQ13]
      next_state.exiting = 1'b0;
    end else if (state.pd_active && !state.exiting &&
                 ((pd_write && !pwdata[CIC_PD_BIT]) ||
                  (state.auto_ctrl[CIC_WAKE_BIT] && misc_set[CIC_ON_BIT]))) begin
      next_state.exiting = 1'b1; // [RQ14] [RQ15]
      next_state.exit_cnt = 11'h000;
    end else if (state.exiting) begin
      if (state.exit_cnt == CIC_EXIT_LAST) begin
        next_state.exiting = 1'b0;
        next_state.pd_active = 1'b0; // [RQ15]
      end else begin
        next_state.exit_cnt = state.exit_cnt + 11'h001;
      end
    end

    // Hard power-down stops everything
    if (!pin_up) begin
      next_state.ctrl.cmd_code = CIC_CMD_IDLE; // [RQ12]
      next_state.cmd_pending = 1'b0;
      next_state.begin_tx = 1'b0;
    end

    next_state.ctrl.unit_run = pin_up && !next_state.pd_active; // [RQ12] [RQ13]
    next_state.ctrl.detector_run = pin_up; // [RQ12] [RQ13]
    // Receiver is independent of the driver enables
    next_state.ctrl.receiver_on = pin_up && !next_state.pd_active; // [RQ17]
    next_state.ctrl.antenna_a_on = next_state.ctrl.unit_run && next_state.drv_en[0]; // [RQ17]
    next_state.ctrl.antenna_b_on = next_state.ctrl.unit_run && next_state.drv_en[1]; // [RQ17]
    // Not reflected in any readable register
    // Hard power-down wins over the forced conductance
    next_state.ctrl.force_conductance = pin_up && next_state.pd_active &&
                                        (next_state.drv_sel != CIC_DRV_SEL_OFF); // [RQ16]

    next_state.high_irq = |(next_state.comm_flags & next_state.comm_en & CIC_HIGH_GROUP); // [RQ10] [RQ25]
    next_state.low_irq = (|(next_state.comm_flags & next_state.comm_en & CIC_LOW_GROUP)) ||
                         (|(next_state.misc_flags & next_state.misc_en)); // [RQ11] [RQ25]
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      state <= CIC_STATE_RST;
    end else begin
      state <= next_state;
    end
  end

  assign pready = state.ready;
  assign prdata = state.rdata;
  assign pslverr = state.slverr;
  assign ctrl = state.ctrl;
  assign high_priority_summary = state.high_irq;
  assign low_priority_summary = state.low_irq;

endmodule

//--- verilog/cic_pkg.sv
package cic_pkg;

  // Register byte offsets
  localparam logic [7:0] CIC_COMM_FLAGS_OFS  = 8'h00;
  localparam logic [7:0] CIC_MISC_FLAGS_OFS  = 8'h04;
  localparam logic [7:0] CIC_COMM_EN_OFS     = 8'h08;
  localparam logic [7:0] CIC_MISC_EN_OFS     = 8'h0C;
  localparam logic [7:0] CIC_STATUS_ONE_OFS  = 8'h10;
  localparam logic [7:0] CIC_ERROR_OFS       = 8'h14;
  localparam logic [7:0] CIC_WATERMARK_OFS   = 8'h18;
  localparam logic [7:0] CIC_COMMAND_OFS     = 8'h1C;
  localparam logic [7:0] CIC_TX_DRIVER_OFS   = 8'h20;
  localparam logic [7:0] CIC_TX_AUTO_OFS     = 8'h24;
  localparam logic [7:0] CIC_BIT_FRAMING_OFS = 8'h28;

  // Field positions in comm_event_flags
  localparam int CIC_TIMER_BIT  = 0;
  localparam int CIC_ERR_BIT    = 1;
  localparam int CIC_LOW_BIT    = 2;
  localparam int CIC_HIGH_BIT   = 3;
  localparam int CIC_IDLE_BIT   = 4;
  localparam int CIC_RX_BIT     = 5;
  localparam int CIC_TX_BIT     = 6;
  // Field positions in misc_event_flags
  localparam int CIC_MODE_BIT   = 0;
  localparam int CIC_OFF_BIT    = 1;
  localparam int CIC_ON_BIT     = 2;
  localparam int CIC_CRC_BIT    = 3;
  // Field positions in command_register, bit_framing_control
  localparam int CIC_PD_BIT     = 4;
  localparam int CIC_BEGIN_BIT  = 7;
  // Field positions in tx_automation_control
  localparam int CIC_WAKE_BIT   = 3;
  localparam int CIC_INIT_BIT   = 2;

  // Group masks over comm_event_flags
  localparam logic [6:0] CIC_HIGH_GROUP = 7'h6C;
  localparam logic [6:0] CIC_LOW_GROUP  = 7'h13;

  // Command codes
  localparam logic [3:0] CIC_CMD_IDLE       = 4'h0;
  localparam logic [3:0] CIC_CMD_TRANSMIT   = 4'h4;
  localparam logic [3:0] CIC_CMD_KEEP       = 4'h7;
  localparam logic [3:0] CIC_CMD_TRANSCEIVE = 4'hC;
  localparam logic [3:0] CIC_CMD_AUTHENT    = 4'hE;
  localparam logic [6:0] CIC_AUTH_ARGS      = 7'h0C;

  localparam logic [6:0] CIC_FIFO_DEPTH = 7'h40;
  localparam logic [1:0] CIC_DRV_SEL_OFF = 2'h0;

  // Soft power-down exit: 1024 cycles
  localparam int          CIC_EXIT_CLOCKS = 1024;
  localparam logic [10:0] CIC_EXIT_LAST   = 11'(CIC_EXIT_CLOCKS - 1);

  typedef struct packed {
    logic [15:0] timer_count;
    logic        tx_payload;
    logic        tx_eof;
    logic        checksum_ready_status;
    logic        rx_stream_end;
    logic        cmd_done;
    logic [6:0]  fifo_level;
    logic [7:0]  error_status;
    logic        tx_active;
    logic        rx_active;
    logic        mode_found;
  } cic_events_t;

  typedef struct packed {
    logic       unit_run;
    logic       detector_run;
    logic       receiver_on;
    logic       antenna_a_on;
    logic       antenna_b_on;
    logic       force_conductance;
    logic [3:0] cmd_code;
    logic       cmd_launch;
    logic       cmd_abort;
    logic       tx_launch;
  } cic_ctrl_t;

  typedef struct packed {
    logic [1:0]  pin_sync;
    logic [1:0]  field_sync;
    logic        field_prev;
    logic [15:0] timer_prev;
    logic        payload_prev;
    logic        crc_prev;
    logic        low_prev;
    logic        high_prev;
    logic [6:0]  comm_flags;
    logic [3:0]  misc_flags;
    logic [6:0]  comm_en;
    logic [3:0]  misc_en;
    logic [5:0]  watermark;
    logic        pd_active;
    logic        exiting;
    logic [10:0] exit_cnt;
    logic [1:0]  drv_en;
    logic [1:0]  drv_sel;
    logic [3:0]  auto_ctrl;
    logic        begin_tx;
    logic        cmd_pending;
    logic        high_irq;
    logic        low_irq;
    logic        ready;
    logic        slverr;
    logic [31:0] rdata;
    cic_ctrl_t   ctrl;
  } cic_state_t;

  localparam cic_state_t CIC_STATE_RST = '0;

endpackage
